// File: rtl/vilp_cfg.svh
// Constants for the vertical interval line processor.
// Assumes inclusion by the package and the design modules.
`ifndef VILP_CFG_SVH
`define VILP_CFG_SVH
`define VILP_FIRST_LINE     10
`define VILP_LAST_LINE      24
`define VILP_NUM_LINES      15
`define VILP_MODE_W         2
`define VILP_PIX_W          10
`define VILP_BLACK_525      10'h0_040
`define VILP_BLACK_625      10'h0_040
`define VILP_READ1_DEFAULT  9'h0_00A
`define VILP_READ2_DEFAULT  9'h0_028
`define VILP_FIRST_DEFAULT  9'h0_00A
`define VILP_LAST_DEFAULT   9'h0_018
`define VILP_LINE_W         9
`define VILP_LINES_525      9'h1_0D
`define VILP_LINES_625      9'h1_39
`define VILP_PRESENT_LINES  4'h3
`endif

// File: rtl/vilp_pkg.sv
// Types shared by the vertical interval line processor modules.
// Assumes the constants header is compiled alongside.
`include "vilp_cfg.svh"
package vilp_pkg;
   typedef enum logic [1:0] {
      VILP_NORMAL = 2'b00,
      VILP_NOTCH  = 2'b01,
      VILP_LUMA   = 2'b10,
      VILP_DELETE = 2'b11
   } vilp_mode_t;
   typedef enum logic [1:0] {
      VILP_WAIT   = 2'b00,
      VILP_SCAN   = 2'b01,
      VILP_FOUND  = 2'b10
   } vilp_tc_t;
endpackage : vilp_pkg

// File: rtl/vilp_notch.sv
// Chroma notch: averages pixels two apart, cancelling the subcarrier.
// Assumes four-times-subcarrier luma samples on the pixel enable.
`include "vilp_cfg.svh"
module vilp_notch #(
   parameter int PIX_W = `VILP_PIX_W
) (
   input  wire logic             clk,
   input  wire logic             rst_n,
   input  wire logic             pix_en,
   input  wire logic [PIX_W-1:0] pix_in,
   output logic      [PIX_W-1:0] pix_out
);
   logic [PIX_W-1:0] d1_r;
   logic [PIX_W-1:0] d2_r;
   logic [PIX_W:0]   sum;
   assign sum = {1'b0, pix_in} + {1'b0, d2_r};
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         d1_r <= '0;
         d2_r <= '0;
      end else if (pix_en) begin
         d1_r <= pix_in;
         d2_r <= d1_r;
      end
   end
   // Half-period spacing puts a zero at the subcarrier
   assign pix_out = sum[PIX_W:1];
endmodule : vilp_notch

// File: rtl/vilp_top.sv
// Vertical interval line processing for one video input channel.
// Assumes line/field strobes from an upstream sync separator.
// What this block does
// - Per-line mode, lines 10 to 24, both fields
// - Normal mode forwards the line unaltered
// - Notch mode removes chroma near subcarrier
// - Luma pass keeps luminance, drops chroma
// - Delete mode outputs black whole line
// - Line numbering follows selected standard
// - One standard at a time, from configuration
// - Status flags are read-only outputs
// - Auto search scans first to last line
// - Otherwise only two reader lines searched
// - Timecode found sets the found flag
// - Range search only while timing locked
// - Locked flag needs auto-timing and alignment
`include "vilp_cfg.svh"
module vilp_top #(
   parameter int NUM_LINES = `VILP_NUM_LINES,
   parameter int PIX_W     = `VILP_PIX_W
) (
   input  wire logic                          CLOCK,
   input  wire logic                          RSTN,
   input  wire logic                          PIX_EN,
   input  wire logic [PIX_W-1:0]              LUMA_IN,
   input  wire logic [PIX_W-1:0]              CHROMA_IN,
   input  wire logic                          LINE_START,
   input  wire logic                          FIELD_START,
   input  wire logic                          FIELD_TWO,
   input  wire logic                          STD_625,
   input  wire logic [2*NUM_LINES*2-1:0]      LINE_MODES,
   input  wire logic                          auto_timecode_search_enable,
   input  wire logic [`VILP_LINE_W-1:0]       SEARCH_FIRST,
   input  wire logic [`VILP_LINE_W-1:0]       SEARCH_LAST,
   input  wire logic [`VILP_LINE_W-1:0]       READ_LINE_ONE,
   input  wire logic [`VILP_LINE_W-1:0]       READ_LINE_TWO,
   input  wire logic                          TC_VALID,
   input  wire logic                          AUTO_TIMING_ENABLE,
   input  wire logic                          GENLOCK_ALIGNED,
   input  wire logic                          SIGNAL_SEEN,
   output logic      [PIX_W-1:0]              LUMA_OUT,
   output logic      [PIX_W-1:0]              CHROMA_OUT,
   output logic [`VILP_LINE_W-1:0]            LINE_NUMBER,
   output logic                               INPUT_DETECTED,
   output logic                               timecode_found_flag,
   output logic                               TIMING_LOCKED,
   output logic                               TC_SEARCHING
);
   // Mode table slicing is fixed at fifteen lines per field
   if (NUM_LINES != `VILP_NUM_LINES || PIX_W < 4) begin : g_bad_params
      $error("vilp_top: unsupported parameters");
   end

   localparam logic [PIX_W-1:0] BLACK = PIX_W'(`VILP_BLACK_525);
   localparam logic [PIX_W-1:0] CHROMA_ZERO = PIX_W'(1) << (PIX_W - 1);

   // Pin-side status levels through three flops
   logic [2:0] seen_s_r;
   logic [2:0] align_s_r;
   logic [2:0] tcv_s_r;
   always_ff @(posedge CLOCK or negedge RSTN) begin
      if (!RSTN) begin
         seen_s_r  <= '0;
         align_s_r <= '0;
         tcv_s_r   <= '0;
      end else begin
         seen_s_r  <= {seen_s_r[1:0], SIGNAL_SEEN};
         align_s_r <= {align_s_r[1:0], GENLOCK_ALIGNED};
         tcv_s_r   <= {tcv_s_r[1:0], TC_VALID};
      end
   end
   logic seen_r;
   logic align_r;
   logic tcv_r;
   always_ff @(posedge CLOCK or negedge RSTN) begin
      if (!RSTN) begin
         seen_r  <= 1'b0;
         align_r <= 1'b0;
         tcv_r   <= 1'b0;
      end else begin
         if (seen_s_r[1] == seen_s_r[2])
            seen_r <= seen_s_r[2];
         if (align_s_r[1] == align_s_r[2])
            align_r <= align_s_r[2];
         if (tcv_s_r[1] == tcv_s_r[2])
            tcv_r <= tcv_s_r[2];
      end
   end

   // Line counter, restarted per field
   logic [`VILP_LINE_W-1:0] line_r;
   logic                    field2_r;
   logic                    std625_r;
   logic [`VILP_LINE_W-1:0] line_max;
   assign line_max = std625_r ? `VILP_LINES_625 : `VILP_LINES_525;
   always_ff @(posedge CLOCK or negedge RSTN) begin
      if (!RSTN) begin
         line_r   <= '0;
         field2_r <= 1'b0;
         std625_r <= 1'b0;
      end else if (FIELD_START) begin
         line_r   <= `VILP_LINE_W'(1);
         field2_r <= FIELD_TWO;
         std625_r <= STD_625;
      end else if (LINE_START && line_r < line_max) begin
         line_r <= line_r + `VILP_LINE_W'(1);
      end
   end

   // Field two numbering restarts at line 1, as field one does, in both standards
   logic [`VILP_LINE_W-1:0] vi_line;
   assign vi_line = line_r;

   logic in_vi;
   logic [3:0] idx;
   assign in_vi = vi_line >= `VILP_LINE_W'(`VILP_FIRST_LINE) &&
                  vi_line <= `VILP_LINE_W'(`VILP_LAST_LINE);
   assign idx = 4'(vi_line - `VILP_LINE_W'(`VILP_FIRST_LINE));

   // Mode table slice: field one low half, field two high half
   vilp_pkg::vilp_mode_t line_mode;
   logic [1:0] mode_bits [2*NUM_LINES];
   genvar g;
   generate
      for (g = 0; g < 2*NUM_LINES; g++) begin : g_mode
         assign mode_bits[g] = LINE_MODES[2*g +: 2];
      end
   endgenerate
   always_comb begin
      line_mode = vilp_pkg::VILP_NORMAL;
      if (in_vi)
         line_mode = vilp_pkg::vilp_mode_t'(
            mode_bits[{1'b0, idx} + (field2_r ? 5'd15 : 5'd0)]);
   end

   logic [PIX_W-1:0] notch_y;
   vilp_notch #(.PIX_W(PIX_W)) u_notch (
      .clk     (CLOCK),
      .rst_n   (RSTN),
      .pix_en  (PIX_EN),
      .pix_in  (LUMA_IN),
      .pix_out (notch_y)
   );

   always_ff @(posedge CLOCK or negedge RSTN) begin
      if (!RSTN) begin
         LUMA_OUT   <= BLACK;
         CHROMA_OUT <= CHROMA_ZERO;
      end else if (PIX_EN) begin
         case (line_mode)
            vilp_pkg::VILP_NORMAL: begin
               LUMA_OUT   <= LUMA_IN;
               CHROMA_OUT <= CHROMA_IN;
            end
            vilp_pkg::VILP_NOTCH: begin
               LUMA_OUT   <= notch_y;
               CHROMA_OUT <= CHROMA_ZERO;
            end
            vilp_pkg::VILP_LUMA: begin
               LUMA_OUT   <= LUMA_IN;
               CHROMA_OUT <= CHROMA_ZERO;
            end
            vilp_pkg::VILP_DELETE: begin
               LUMA_OUT   <= BLACK;
               CHROMA_OUT <= CHROMA_ZERO;
            end
            default: begin
               LUMA_OUT   <= LUMA_IN;
               CHROMA_OUT <= CHROMA_IN;
            end
         endcase
      end
   end

   always_ff @(posedge CLOCK or negedge RSTN) begin
      if (!RSTN)
         LINE_NUMBER <= '0;
      else
         LINE_NUMBER <= vi_line;
   end

   // Status outputs: driven by the device; the locked flag is also gated by the auto-timing enable setting
   always_ff @(posedge CLOCK or negedge RSTN) begin
      if (!RSTN) begin
         INPUT_DETECTED <= 1'b0;
         TIMING_LOCKED  <= 1'b0;
      end else begin
         INPUT_DETECTED <= seen_r;
         TIMING_LOCKED  <= AUTO_TIMING_ENABLE & align_r & seen_r;
      end
   end

   // Searched line decision
   logic range_hit;
   logic fixed_hit;
   logic search_now;
   assign range_hit = vi_line >= SEARCH_FIRST && vi_line <= SEARCH_LAST;
   assign fixed_hit = vi_line == READ_LINE_ONE || vi_line == READ_LINE_TWO;
   assign search_now = auto_timecode_search_enable ?
      (range_hit && TIMING_LOCKED) : fixed_hit;

   always_ff @(posedge CLOCK or negedge RSTN) begin
      if (!RSTN)
         TC_SEARCHING <= 1'b0;
      else
         TC_SEARCHING <= search_now;
   end

   // Found flag held per field; a hit in the field-start cycle is kept
   logic found_field_r;
   always_ff @(posedge CLOCK or negedge RSTN) begin
      if (!RSTN) begin
         found_field_r       <= 1'b0;
         timecode_found_flag <= 1'b0;
      end else begin
         if (search_now && tcv_r)
            found_field_r <= 1'b1;
         else if (FIELD_START)
            found_field_r <= 1'b0;
         if (FIELD_START)
            timecode_found_flag <= found_field_r | (search_now & tcv_r);
         else if (search_now && tcv_r)
            timecode_found_flag <= 1'b1;
      end
   end

   // Assertions
   property p_delete_black;
      @(posedge CLOCK) disable iff (!RSTN)
      (PIX_EN && line_mode == vilp_pkg::VILP_DELETE) |=> LUMA_OUT == BLACK;
   endproperty
   a_delete_black: assert property (p_delete_black)
      else $error("Deleted line not black");

   property p_normal_pass;
      @(posedge CLOCK) disable iff (!RSTN)
      (PIX_EN && line_mode == vilp_pkg::VILP_NORMAL) |=>
         LUMA_OUT == $past(LUMA_IN) && CHROMA_OUT == $past(CHROMA_IN);
   endproperty
   a_normal_pass: assert property (p_normal_pass)
      else $error("Normal line altered");

   property p_luma_pass;
      @(posedge CLOCK) disable iff (!RSTN)
      (PIX_EN && line_mode == vilp_pkg::VILP_LUMA) |=>
         LUMA_OUT == $past(LUMA_IN) && CHROMA_OUT == CHROMA_ZERO;
   endproperty
   a_luma_pass: assert property (p_luma_pass)
      else $error("Luma pass wrong");

   property p_notch_chroma;
      @(posedge CLOCK) disable iff (!RSTN)
      (PIX_EN && line_mode == vilp_pkg::VILP_NOTCH) |=>
         CHROMA_OUT == CHROMA_ZERO;
   endproperty
   a_notch_chroma: assert property (p_notch_chroma)
      else $error("Notch kept chroma");

   property p_outside_vi;
      @(posedge CLOCK) disable iff (!RSTN)
      !in_vi |-> line_mode == vilp_pkg::VILP_NORMAL;
   endproperty
   a_outside_vi: assert property (p_outside_vi)
      else $error("Mode applied outside lines 10 to 24");

   property p_lock;
      @(posedge CLOCK) disable iff (!RSTN)
      !AUTO_TIMING_ENABLE |=> !TIMING_LOCKED;
   endproperty
   a_lock: assert property (p_lock)
      else $error("Locked without auto-timing");

   property p_range_lock;
      @(posedge CLOCK) disable iff (!RSTN)
      (auto_timecode_search_enable && !TIMING_LOCKED) |-> !search_now;
   endproperty
   a_range_lock: assert property (p_range_lock)
      else $error("Range search while unlocked");

   property p_found;
      @(posedge CLOCK) disable iff (!RSTN)
      (search_now && tcv_r) |=> timecode_found_flag;
   endproperty
   a_found: assert property (p_found)
      else $error("Timecode hit not flagged");

   property p_fixed;
      @(posedge CLOCK) disable iff (!RSTN)
      (!auto_timecode_search_enable && !fixed_hit) |=> !TC_SEARCHING;
   endproperty
   a_fixed: assert property (p_fixed)
      else $error("Searched off reader lines");

   property p_detect;
      @(posedge CLOCK) disable iff (!RSTN)
      seen_r |=> INPUT_DETECTED;
   endproperty
   a_detect: assert property (p_detect)
      else $error("Input detect not shown");

   c_delete: cover property (@(posedge CLOCK) disable iff (!RSTN)
      PIX_EN && line_mode == vilp_pkg::VILP_DELETE);
   c_notch: cover property (@(posedge CLOCK) disable iff (!RSTN)
      PIX_EN && line_mode == vilp_pkg::VILP_NOTCH);
   c_found: cover property (@(posedge CLOCK) disable iff (!RSTN)
      $rose(timecode_found_flag));
   c_lock: cover property (@(posedge CLOCK) disable iff (!RSTN)
      $rose(TIMING_LOCKED));
endmodule : vilp_top

// File: test/vilp_src.sv
// Behavioural video source and sync strobes facing the line processor.
// Assumes its tasks are called from the bench; all changes follow clk rise.
module vilp_src #(
   parameter int PIX_W = 10
) (
   input  wire logic             clk,
   output logic                  pix_en,
   output logic      [PIX_W-1:0] luma,
   output logic      [PIX_W-1:0] chroma,
   output logic                  line_start,
   output logic                  field_start,
   output logic                  field_two,
   output logic                  std_625,
   output logic                  tc_valid
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      {pix_en, line_start, field_start, field_two, std_625, tc_valid} = '0;
      luma   = '0;
      chroma = '0;
   end
   // Field flags held after the strobe, as a real separator would
   task automatic new_field(input logic f2, input logic s625);
      @(posedge clk);
      field_two   <= f2;
      std_625     <= s625;
      field_start <= 1'b1;
      @(posedge clk);
      field_start <= 1'b0;
   endtask : new_field
   task automatic next_lines(input int n);
      repeat (n) begin
         @(posedge clk);
         line_start <= 1'b1;
         @(posedge clk);
         line_start <= 1'b0;
      end
   endtask : next_lines
   // Data inverted once not qualified, so stale values never match
   task automatic pixel(input logic [PIX_W-1:0] l, input logic [PIX_W-1:0] c);
      @(posedge clk);
      pix_en <= 1'b1;
      luma   <= l;
      chroma <= c;
      @(posedge clk);
      pix_en <= 1'b0;
      luma   <= ~l;
      chroma <= ~c;
      @(posedge clk);
      #1;
   endtask : pixel
   // Long enough to cross the three-flop synchroniser
   task automatic tc_burst();
      @(posedge clk);
      tc_valid <= 1'b1;
      repeat (10) @(posedge clk);
      tc_valid <= 1'b0;
      repeat (6) @(posedge clk);
      #1;
   endtask : tc_burst
endmodule : vilp_src

// File: test/vilp_top_test.sv
// Self-checking bench for the vertical interval line processor.
// Assumes the source model drives all video and sync inputs.
`include "vilp_cfg.svh"
module vilp_top_test;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk, rstn, auto_en, ate, aligned, seen;
   logic [59:0] modes;
   logic [8:0]  first, last, line_no, rd1, rd2;
   logic        pix_en, ls, fs, f2, s625, tcv;
   logic [9:0]  li, ci, lo, co;
   logic        det, found, locked, searching;
   int          mismatches, checks_done;
   vilp_src src (.clk(clk), .pix_en(pix_en), .luma(li), .chroma(ci),
      .line_start(ls), .field_start(fs), .field_two(f2), .std_625(s625),
      .tc_valid(tcv));
   vilp_top dut (.CLOCK(clk), .RSTN(rstn), .PIX_EN(pix_en), .LUMA_IN(li),
      .CHROMA_IN(ci), .LINE_START(ls), .FIELD_START(fs), .FIELD_TWO(f2),
      .STD_625(s625), .LINE_MODES(modes), .auto_timecode_search_enable(auto_en),
      .SEARCH_FIRST(first), .SEARCH_LAST(last), .READ_LINE_ONE(rd1),
      .READ_LINE_TWO(rd2), .TC_VALID(tcv), .AUTO_TIMING_ENABLE(ate),
      .GENLOCK_ALIGNED(aligned), .SIGNAL_SEEN(seen), .LUMA_OUT(lo),
      .CHROMA_OUT(co), .LINE_NUMBER(line_no), .INPUT_DETECTED(det),
      .timecode_found_flag(found), .TIMING_LOCKED(locked),
      .TC_SEARCHING(searching));
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         mismatches++;
         $display("FAIL t=%0t seen=%h exp=%h", $time, got, exp);
      end
   endtask : check
   task automatic close_out();
      $display("mismatches=%0d checks_done=%0d", mismatches, checks_done);
      if (mismatches == 0 && checks_done > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : close_out
   task automatic settle();
      repeat (8) @(posedge clk);
      #1;
   endtask : settle
   initial begin
      repeat (20000) @(posedge clk);
      mismatches++;
      close_out();
   end
   initial begin
      {rstn, auto_en, ate, aligned, seen} = '0;
      first = 9'h0_00C;
      last  = 9'h0_00E;
      rd1   = `VILP_READ1_DEFAULT;
      rd2   = `VILP_READ2_DEFAULT;
      modes = '0;
      // Field one lines 11..13, field two line 10
      modes[3:2]   = vilp_pkg::VILP_DELETE;
      modes[5:4]   = vilp_pkg::VILP_LUMA;
      modes[7:6]   = vilp_pkg::VILP_NOTCH;
      modes[31:30] = vilp_pkg::VILP_DELETE;
      @(posedge clk);
      #1;
      check(16'(lo), 16'h0_040);
      check(16'(co), 16'h0_200);
      check(16'({det, found, locked}), 16'h0_000);
      repeat (2) @(posedge clk);
      rstn    <= 1'b1;
      seen    <= 1'b1;
      aligned <= 1'b1;
      settle();
      check(16'(det), 16'h0_001);
      check(16'(locked), 16'h0_000);
      src.new_field(1'b0, 1'b0);
      src.next_lines(9);
      // Line number and search flag are registered: one edge behind
      @(posedge clk);
      #1;
      check(16'(line_no), 16'h0_00A);
      check(16'(searching), 16'h0_001);
      src.pixel(10'h1_23, 10'h1_55);
      check(32'({lo, co}), 32'({10'h1_23, 10'h1_55}));
      src.next_lines(1);
      src.pixel(10'h3_A0, 10'h1_11);
      check(16'(lo), 16'h0_040);
      src.next_lines(1);
      src.pixel(10'h1_A0, 10'h2_F0);
      check(32'({lo, co}), 32'({10'h1_A0, 10'h2_00}));
      src.next_lines(1);
      src.pixel(10'h1_00, 10'h2_00);
      src.pixel(10'h1_00, 10'h2_00);
      src.pixel(10'h3_00, 10'h2_00);
      check(16'(lo), 16'h0_200);
      src.pixel(10'h3_00, 10'h2_00);
      check(16'(lo), 16'h0_200);
      src.next_lines(1);
      src.tc_burst();
      check(16'({searching, found}), 16'h0_000);
      src.new_field(1'b1, 1'b0);
      src.next_lines(9);
      src.pixel(10'h2_22, 10'h1_00);
      check(16'(lo), 16'h0_040);
      src.tc_burst();
      check(16'(found), 16'h0_001);
      src.next_lines(300);
      #1;
      check(16'(line_no), 16'(`VILP_LINES_525));
      src.new_field(1'b0, 1'b1);
      src.next_lines(330);
      #1;
      check(16'(line_no), 16'(`VILP_LINES_625));
      @(posedge clk);
      ate <= 1'b1;
      settle();
      check(16'(locked), 16'h0_001);
      src.new_field(1'b0, 1'b0);
      src.new_field(1'b1, 1'b0);
      settle();
      check(16'(found), 16'h0_000);
      @(posedge clk);
      auto_en <= 1'b1;
      src.new_field(1'b0, 1'b0);
      src.next_lines(12);
      src.tc_burst();
      check(16'({searching, found}), 16'h0_003);
      src.next_lines(2);
      @(posedge clk);
      #1;
      check(16'(searching), 16'h0_000);
      // Moved range now covers the current line 15
      @(posedge clk);
      first <= 9'h0_00F;
      last  <= 9'h0_010;
      @(posedge clk);
      #1;
      check(16'(searching), 16'h0_001);
      @(posedge clk);
      aligned <= 1'b0;
      settle();
      check(16'(locked), 16'h0_000);
      src.new_field(1'b0, 1'b0);
      src.next_lines(14);
      @(posedge clk);
      #1;
      check(16'(searching), 16'h0_000);
      // Non-default reader lines, all lines set to delete
      @(posedge clk);
      auto_en <= 1'b0;
      rd1     <= 9'h0_00F;
      rd2     <= 9'h0_011;
      modes   <= '1;
      src.new_field(1'b0, 1'b0);
      src.next_lines(14);
      @(posedge clk);
      #1;
      check(16'(searching), 16'h0_001);
      src.pixel(10'h1_55, 10'h0_AA);
      check(32'({lo, co}), 32'({10'h0_40, 10'h2_00}));
      src.next_lines(1);
      @(posedge clk);
      #1;
      check(16'(searching), 16'h0_000);
      src.next_lines(1);
      @(posedge clk);
      #1;
      check(16'(searching), 16'h0_001);
      @(posedge clk);
      seen <= 1'b0;
      settle();
      check(16'(det), 16'h0_000);
      close_out();
   end
endmodule : vilp_top_test
